// ---- shared/pisc_pkg.sv ----
// constants, types and helpers shared by the PCI interrupt steering block
package pisc_pkg;
    localparam int unsigned NUM_LINES = 4;
    localparam int unsigned NUM_IRQ = 16;
    localparam int unsigned STAT_W = 5;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_STEER_A = 8'h60;
    localparam logic [7:0] IDX_STEER_D = 8'h63;
    localparam logic [7:0] IDX_SERIALIZED_INTERRUPT_WIRE = 8'h64;
    localparam logic [7:0] IDX_INT_STATUS = 8'h65;
    localparam logic [7:0] IDX_INT_MASK = 8'h66;
    localparam logic [7:0] IDX_ROUTE_STATE = 8'h67;
    // steering register fields
    localparam int unsigned STEER_DIS_BIT = 7;
    localparam int unsigned STEER_SEL_MSB = 3;
    localparam logic [7:0] STEER_RST = 8'h80;
    // serial interrupt control fields
    localparam int unsigned SER_EN_BIT = 7;
    localparam int unsigned SER_MODE_BIT = 6;
    localparam int unsigned SER_FS_LSB = 2;
    localparam int unsigned SER_PW_LSB = 0;
    localparam logic [7:0] SERIALIZED_INTERRUPT_WIRE_RST = 8'h10;
    // frame timing
    localparam logic [6:0] FRAME_BASE_SLOTS = 7'h11;
    localparam logic [6:0] SLOT_CLKS = 7'h03;
    localparam logic [3:0] PW_CLKS_00 = 4'h4;
    localparam logic [3:0] PW_CLKS_01 = 4'h6;
    localparam logic [3:0] PW_CLKS_10 = 4'h8;
    // status bit of the frame-done event; bits below it are line events
    localparam int unsigned STAT_FRAME_BIT = 4;

    typedef enum logic [1:0] {FR_IDLE, FR_START, FR_FRAME} pisc_frame_t;

    // one-hot target for a routing code, zero for a reserved code
    function automatic logic [15:0] pisc_route_onehot(input logic [3:0] sel);
        logic [15:0] hot;
        hot = 16'h0000;
        unique case (sel)
            4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hA, 4'hB, 4'hC, 4'hE, 4'hF: hot[sel] = 1'b1;
            default: hot = 16'h0000;
        endcase
        return hot;
    endfunction : pisc_route_onehot

    // start pulse length in clocks; the reserved code behaves as the longest
    function automatic logic [3:0] pisc_pulse_clks(input logic [1:0] pw);
        logic [3:0] n;
        n = PW_CLKS_10;
        unique case (pw)
            2'h0: n = PW_CLKS_00;
            2'h1: n = PW_CLKS_01;
            2'h2: n = PW_CLKS_10;
            2'h3: n = PW_CLKS_10;
        endcase
        return n;
    endfunction : pisc_pulse_clks

    // per bit: take the new level once the two later sync stages agree
    function automatic logic [15:0] pisc_agree(input logic [15:0] s2, input logic [15:0] s3,
                                               input logic [15:0] f);
        return (~(s2 ^ s3) & s3) | ((s2 ^ s3) & f);
    endfunction : pisc_agree
endpackage : pisc_pkg

// ---- shared/pisc_sfr_if.sv ----
// link between frame sequencer and start pulse generator
`timescale 1ns/1ps
`default_nettype none
interface pisc_sfr_if;
    logic start;
    logic [3:0] width_clks;
    logic drive;
    logic wire_out;
    logic done;
    modport ctl (output start, output width_clks, input drive, input wire_out, input done);
    modport gen (input start, input width_clks, output drive, output wire_out, output done);
endinterface : pisc_sfr_if
`default_nettype wire

// ---- core/pisc_start_pulse.sv ----
// start frame pulse generator on the serialized interrupt wire
`timescale 1ns/1ps
`default_nettype none
module pisc_start_pulse (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // sequencer link
    pisc_sfr_if.gen sfr
);
    import pisc_pkg::*;

    logic [3:0] cnt_q;
    logic drive_q;
    logic out_q;
    logic done_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 4'h0;
            drive_q <= 1'b0;
            out_q <= 1'b1;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (sfr.start && cnt_q == 4'h0) begin
                // hold the wire low for exactly width_clks cycles
                cnt_q <= sfr.width_clks;
                drive_q <= 1'b1;
                out_q <= 1'b0;
            end else if (cnt_q != 4'h0) begin
                cnt_q <= cnt_q - 4'h1;
                if (cnt_q == 4'h1) begin
                    drive_q <= 1'b0;
                    out_q <= 1'b1;
                    done_q <= 1'b1;
                end
            end
        end
    end

    assign sfr.drive = drive_q;
    assign sfr.wire_out = out_q;
    assign sfr.done = done_q;
endmodule : pisc_start_pulse
`default_nettype wire

// ---- core/pisc_steer_top.sv ----
// PCI interrupt steering and serialized interrupt control with APB registers
`timescale 1ns/1ps
`default_nettype none
module pisc_steer_top (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // interrupt sources, asynchronous pins
    input wire logic [3:0] shared_pci_int_lines_n,
    input wire logic [15:0] isa_irq,
    // serialized interrupt wire, open drain
    input wire logic serialized_interrupt_wire_in,
    output logic serialized_interrupt_wire_out,
    output logic serialized_interrupt_wire_oe,
    // to the cascaded controller inputs
    output logic [15:0] ctl_irq,
    // block interrupt
    output logic irq
);
    import pisc_pkg::*;

    // ---------------- input synchronisers ----------------
    logic [3:0] line_s1_q, line_s2_q, line_s3_q, line_f_q, line_prev_q;
    logic [15:0] isa_s1_q, isa_s2_q, isa_s3_q, isa_f_q;
    logic wire_s1_q, wire_s2_q, wire_s3_q, wire_f_q;
    logic [15:0] line_agree, wire_agree;

    // filter outputs widened to the helper's width; only the low bits are used
    assign line_agree = pisc_agree({12'h000, line_s2_q}, {12'h000, line_s3_q}, {12'h000, line_f_q});
    assign wire_agree = pisc_agree({15'h0000, wire_s2_q}, {15'h0000, wire_s3_q}, {15'h0000, wire_f_q});

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_s1_q <= 4'hF;
            line_s2_q <= 4'hF;
            line_s3_q <= 4'hF;
            line_f_q <= 4'hF;
            line_prev_q <= 4'hF;
        end else begin
            line_s1_q <= shared_pci_int_lines_n;
            line_s2_q <= line_s1_q;
            line_s3_q <= line_s2_q;
            line_f_q <= line_agree[3:0];
            line_prev_q <= line_f_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            isa_s1_q <= 16'h0000;
            isa_s2_q <= 16'h0000;
            isa_s3_q <= 16'h0000;
            isa_f_q <= 16'h0000;
        end else begin
            isa_s1_q <= isa_irq;
            isa_s2_q <= isa_s1_q;
            isa_s3_q <= isa_s2_q;
            isa_f_q <= pisc_agree(isa_s2_q, isa_s3_q, isa_f_q);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wire_s1_q <= 1'b1;
            wire_s2_q <= 1'b1;
            wire_s3_q <= 1'b1;
            wire_f_q <= 1'b1;
        end else begin
            wire_s1_q <= serialized_interrupt_wire_in;
            wire_s2_q <= wire_s1_q;
            wire_s3_q <= wire_s2_q;
            wire_f_q <= wire_agree[0];
        end
    end

    // ---------------- registers ----------------
    logic [3:0] steer_dis_q;
    logic [3:0] steer_sel_q [NUM_LINES];
    logic ser_en_q, ser_mode_q;
    logic [3:0] ser_fs_q;
    logic [1:0] ser_pw_q;
    logic [STAT_W-1:0] stat_q, mask_q, stat_set;
    logic [7:0] steer_rd [NUM_LINES];

    // APB decode
    logic [7:0] idx;
    logic in_range, mapped, is_steer, setup, access, wr;
    logic [1:0] steer_line;
    assign idx = paddr[9:2];
    assign in_range = (paddr[11:10] == 2'h0);
    assign is_steer = in_range && idx >= IDX_STEER_A && idx <= IDX_STEER_D;
    assign steer_line = 2'(idx - IDX_STEER_A);
    assign mapped = is_steer || (in_range && idx >= IDX_SERIALIZED_INTERRUPT_WIRE && idx <= IDX_ROUTE_STATE);
    assign setup = psel && !penable;
    assign access = psel && penable && pready;
    assign wr = access && pwrite && pstrb[0] && mapped;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            steer_dis_q <= 4'hF;
            for (int i = 0; i < NUM_LINES; i++) begin
                steer_sel_q[i] <= STEER_RST[STEER_SEL_MSB:0];
            end
        end else if (wr && is_steer) begin
            steer_dis_q[steer_line] <= pwdata[STEER_DIS_BIT];
            steer_sel_q[steer_line] <= pwdata[STEER_SEL_MSB:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ser_en_q <= SERIALIZED_INTERRUPT_WIRE_RST[SER_EN_BIT];
            ser_mode_q <= SERIALIZED_INTERRUPT_WIRE_RST[SER_MODE_BIT];
            ser_fs_q <= SERIALIZED_INTERRUPT_WIRE_RST[SER_FS_LSB+3:SER_FS_LSB];
            ser_pw_q <= SERIALIZED_INTERRUPT_WIRE_RST[SER_PW_LSB+1:SER_PW_LSB];
        end else if (wr && idx == IDX_SERIALIZED_INTERRUPT_WIRE) begin
            ser_en_q <= pwdata[SER_EN_BIT];
            ser_mode_q <= pwdata[SER_MODE_BIT];
            ser_fs_q <= pwdata[SER_FS_LSB+3:SER_FS_LSB];
            ser_pw_q <= pwdata[SER_PW_LSB+1:SER_PW_LSB];
        end
    end

    // sticky events: a set in the clearing cycle survives
    logic [STAT_W-1:0] stat_clr;
    assign stat_clr = (wr && idx == IDX_INT_STATUS) ? pwdata[STAT_W-1:0] : '0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_q <= '0;
        end else begin
            stat_q <= (stat_q & ~stat_clr) | stat_set;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_q <= '0;
        end else if (wr && idx == IDX_INT_MASK) begin
            mask_q <= pwdata[STAT_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(stat_q & mask_q);
        end
    end

    // ---------------- steering ----------------
    logic [15:0] route_target, route_act, ctl_irq_d;

    always_comb begin
        route_target = 16'h0000;
        route_act = 16'h0000;
        for (int i = 0; i < NUM_LINES; i++) begin
            if (!steer_dis_q[i]) begin
                // several lines may land on one input and are ORed there
                route_target = route_target | pisc_route_onehot(steer_sel_q[i]);
                if (!line_f_q[i]) begin
                    route_act = route_act | pisc_route_onehot(steer_sel_q[i]);
                end
            end
        end
        // a steered target ignores its own ISA request
        ctl_irq_d = (isa_f_q & ~route_target) | route_act;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_irq <= 16'h0000;
        end else begin
            ctl_irq <= ctl_irq_d;
        end
    end

    // ---------------- serialized interrupt frames ----------------
    pisc_sfr_if sfr ();
    pisc_frame_t fr_q;
    logic start_q;
    logic [6:0] frame_cnt_q;
    logic frame_done;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fr_q <= FR_IDLE;
            start_q <= 1'b0;
            frame_cnt_q <= 7'h00;
        end else begin
            start_q <= 1'b0;
            unique case (fr_q)
                FR_IDLE: begin
                    // continuous runs back to back; quiet waits for a peripheral
                    if (ser_en_q && (ser_mode_q || !wire_f_q)) begin
                        start_q <= 1'b1;
                        fr_q <= FR_START;
                    end
                end
                FR_START: begin
                    if (sfr.done) begin
                        frame_cnt_q <= 7'((FRAME_BASE_SLOTS + {3'h0, ser_fs_q}) * SLOT_CLKS);
                        fr_q <= FR_FRAME;
                    end
                end
                FR_FRAME: begin
                    frame_cnt_q <= frame_cnt_q - 7'h01;
                    if (frame_cnt_q <= 7'h01) begin
                        fr_q <= FR_IDLE;
                    end
                end
            endcase
        end
    end

    assign frame_done = (fr_q == FR_FRAME) && (frame_cnt_q <= 7'h01);
    assign sfr.start = start_q;
    assign sfr.width_clks = pisc_pulse_clks(ser_pw_q);

    pisc_start_pulse u_pulse (
        .pclk(pclk),
        .presetn(presetn),
        .sfr(sfr.gen)
    );

    assign serialized_interrupt_wire_out = sfr.wire_out;
    assign serialized_interrupt_wire_oe = sfr.drive;

    // events: a line newly asserted, a frame finished
    always_comb begin
        stat_set = '0;
        stat_set[NUM_LINES-1:0] = line_prev_q & ~line_f_q;
        stat_set[STAT_FRAME_BIT] = frame_done;
    end

    // ---------------- read path ----------------
    logic [31:0] rd_data;

    always_comb begin
        for (int i = 0; i < NUM_LINES; i++) begin
            steer_rd[i] = {steer_dis_q[i], 3'h0, steer_sel_q[i]};
        end
        rd_data = 32'h0000_0000;
        if (is_steer) begin
            rd_data[7:0] = steer_rd[steer_line];
        end else if (in_range && idx == IDX_SERIALIZED_INTERRUPT_WIRE) begin
            rd_data[7:0] = {ser_en_q, ser_mode_q, ser_fs_q, ser_pw_q};
        end else if (in_range && idx == IDX_INT_STATUS) begin
            rd_data[STAT_W-1:0] = stat_q;
        end else if (in_range && idx == IDX_INT_MASK) begin
            rd_data[STAT_W-1:0] = mask_q;
        end else if (in_range && idx == IDX_ROUTE_STATE) begin
            rd_data[15:0] = ctl_irq;
        end
    end

    // one wait-free access phase; data and error captured in setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= setup;
            if (setup) begin
                pslverr <= !mapped;
                prdata <= pwrite ? 32'h0000_0000 : rd_data;
            end else if (access) begin
                pslverr <= 1'b0;
                prdata <= 32'h0000_0000;
            end
        end
    end
endmodule : pisc_steer_top
`default_nettype wire

// ---- test/pisc_partner.sv ----
// model of the PCI agents and a serialized interrupt peripheral
`timescale 1ns/1ps
`default_nettype none
module pisc_partner (
    // requests from the bench
    input wire logic [3:0] agent_req,
    input wire logic per_low,
    // block pins
    input wire logic wire_oe,
    output logic [3:0] lines_n,
    output logic wire_lvl
);
    // agents pull their shared line low while requesting
    assign lines_n = ~agent_req;
    // open drain with pull-up: high unless the block or the peripheral pulls low
    assign wire_lvl = !(wire_oe || per_low);
endmodule : pisc_partner
`default_nettype wire

// ---- test/pisc_steer_top_properties.sv ----
// port checker for the steering block
`timescale 1ns/1ps
`default_nettype none
module pisc_steer_top_properties (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // serialized wire
    input wire logic serialized_interrupt_wire_out,
    input wire logic serialized_interrupt_wire_oe
);
    import pisc_pkg::*;
    logic [7:0] m_q [5];
    logic [3:0] oc_q;
    logic [3:0] pw_n;
    logic oe;
    wire logic hit = paddr[11:5] == 7'h0C && paddr[4:2] < 3'h5;
    assign oe = serialized_interrupt_wire_oe;
    assign pw_n = (m_q[4][1:0] == 2'h0) ? 4'h4 : (m_q[4][1:0] == 2'h1) ? 4'h6 : 4'h8;
    // mirror of the five configuration bytes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 4; i++) m_q[i] <= STEER_RST;
            m_q[4] <= SERIALIZED_INTERRUPT_WIRE_RST;
        end else if (psel && penable && pready && pwrite && pstrb[0] && hit) begin
            m_q[paddr[4:2]] <= (paddr[4:2] == 3'h4) ? pwdata[7:0] : (pwdata[7:0] & 8'h8F);
        end
    end
    // length of the current low drive on the wire
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) oc_q <= 4'h0;
        else oc_q <= oe ? oc_q + 4'h1 : 4'h0;
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_setup_ready: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error answer malformed");
    a_idle_zero: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside access");
    a_rd_mirror: assert property (pready && !pwrite && hit |-> prdata == {24'h0, m_q[paddr[4:2]]})
        else $error("register read mismatch");
    a_rsvd_zero: assert property (pready && !pwrite && paddr[11:4] == 8'h18 |-> prdata[6:4] == 3'h0)
        else $error("reserved steering bits set");
    a_pulse_min: assert property ($rose(oe) |-> oe [*4])
        else $error("start pulse too short");
    a_pulse_len: assert property ($fell(oe) |-> oc_q == pw_n)
        else $error("start pulse length wrong");
    a_oe_drive: assert property (oe != serialized_interrupt_wire_out)
        else $error("wire drive and enable disagree");
    a_frame_en: assert property ($rose(oe) |-> $past(m_q[4][7], 2) || $past(m_q[4][7], 3) || $past(m_q[4][7], 4))
        else $error("frame started while disabled");
    c_err: cover property (pslverr);
    c_pulse8: cover property ($fell(oe) && oc_q == 4'h8);
    c_quiet: cover property ($rose(oe) && !m_q[4][6]);
endmodule : pisc_steer_top_properties
bind pisc_steer_top pisc_steer_top_properties pisc_steer_top_properties_i (.pclk, .presetn, .paddr, .psel,
    .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr, .serialized_interrupt_wire_out,
    .serialized_interrupt_wire_oe);
`default_nettype wire

// ---- test/testbench.sv ----
// self-checking bench for the steering block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import pisc_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hF;
    logic [15:0] isa_irq = 16'h0000;
    logic [3:0] req = 4'h0;
    logic per_low = 1'b0;
    logic [31:0] prdata, rdv;
    logic pready, pslverr, w_in, w_out, w_oe, irq, erv;
    logic [3:0] lines_n;
    logic [15:0] ctl_irq, h;
    logic [7:0] cd [4] = '{8'h03, 8'h05, 8'h0E, 8'h0F};
    logic [3:0] pe [4] = '{4'h4, 4'h6, 4'h8, 4'h8};
    int n_errors = 0;
    int compares = 0;
    int cyc = 0;
    int w;
    always #20 pclk = ~pclk;
    pisc_steer_top pisc_steer_top_i (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .shared_pci_int_lines_n(lines_n), .isa_irq,
        .serialized_interrupt_wire_in(w_in), .serialized_interrupt_wire_out(w_out),
        .serialized_interrupt_wire_oe(w_oe), .ctl_irq, .irq);
    pisc_partner pisc_partner_i (.agent_req(req), .per_low, .wire_oe(w_oe), .lines_n, .wire_lvl(w_in));
    task automatic give_verdict();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : give_verdict
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic xfer(input logic [11:0] a, input logic wr, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        paddr <= a;
        pwrite <= wr;
        pwdata <= {24'h0, d};
        psel <= 1'b1;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdv = prdata;
        erv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) chk("pready", 1, 0);
    endtask : xfer
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        xfer(a, 1'b0, 8'h00);
        chk($sformatf("read %h", a), e, rdv);
    endtask : rd
    // waits a bounded time for a start pulse and returns its length
    task automatic pulse(output int n_hi);
        int n;
        n = 0;
        n_hi = 0;
        while (w_oe !== 1'b1 && n < 200) begin
            @(posedge pclk);
            n++;
        end
        while (w_oe === 1'b1 && n_hi < 20) begin
            @(posedge pclk);
            n_hi++;
        end
    endtask : pulse
    function automatic logic [15:0] hot(input logic [3:0] c);
        return (c inside {[4'h3:4'h7], [4'h9:4'hC], 4'hE, 4'hF}) ? 16'h0001 << c : 16'h0000;
    endfunction : hot
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 40000) begin
            n_errors++;
            give_verdict();
        end
    end
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 4; i++) rd(12'h180 + 12'(i * 4), 32'h80);
        rd(12'h190, 32'h10);
        rd(12'h194, 32'h0);
        rd(12'h198, 32'h0);
        xfer(12'h1A0, 1'b1, 8'h5A);
        chk("wr err", 1, erv);
        rd(12'h1A0, 32'h0);
        chk("rd err", 1, erv);
        xfer(12'h180, 1'b1, 8'hFF);
        rd(12'h180, 32'h8F);
        pstrb <= 4'h0;
        xfer(12'h180, 1'b1, 8'h03);
        pstrb <= 4'hF;
        rd(12'h180, 32'h8F);
        for (int c = 0; c < 16; c++) begin
            xfer(12'h180, 1'b1, 8'(c));
            req <= 4'h1;
            isa_irq <= 16'h0000;
            repeat (8) @(posedge pclk);
            chk("route", hot(4'(c)), ctl_irq);
            req <= 4'h0;
            isa_irq <= 16'hFFFF;
            repeat (8) @(posedge pclk);
            h = ~hot(4'(c));
            chk("isa mask", h, ctl_irq);
        end
        xfer(12'h180, 1'b1, 8'h83);
        req <= 4'h1;
        isa_irq <= 16'h0000;
        repeat (8) @(posedge pclk);
        chk("disabled", 0, ctl_irq);
        for (int k = 0; k < 2; k++) begin
            for (int i = 0; i < 4; i++) xfer(12'h180 + 12'(i * 4), 1'b1, k ? 8'h09 : cd[i]);
            for (int i = 0; i < 5; i++) begin
                req <= (i == 4) ? 4'hF : 4'(1 << i);
                repeat (8) @(posedge pclk);
                h = k ? 16'h0200 : ((i == 4) ? 16'hC028 : hot(cd[i][3:0]));
                chk("line", h, ctl_irq);
            end
            rd(12'h19C, {16'h0, h});
        end
        req <= 4'h0;
        repeat (8) @(posedge pclk);
        xfer(12'h194, 1'b1, 8'h1F);
        rd(12'h194, 32'h0);
        xfer(12'h198, 1'b1, 8'h02);
        req <= 4'h2;
        repeat (8) @(posedge pclk);
        chk("irq set", 1, irq);
        rd(12'h194, 32'h02);
        xfer(12'h198, 1'b1, 8'h01);
        repeat (2) @(posedge pclk);
        chk("irq masked", 0, irq);
        xfer(12'h198, 1'b1, 8'h02);
        repeat (2) @(posedge pclk);
        chk("irq unmasked", 1, irq);
        xfer(12'h194, 1'b1, 8'h02);
        repeat (2) @(posedge pclk);
        chk("irq cleared", 0, irq);
        for (int p = 0; p < 4; p++) begin
            xfer(12'h190, 1'b1, 8'hD0 | 8'(p));
            pulse(w);
            chk("pulse width", 32'(pe[p]), w);
        end
        rd(12'h190, 32'hD3);
        rd(12'h194, 32'h10);
        xfer(12'h190, 1'b1, 8'h50);
        pulse(w);
        chk("disabled pulse", 0, w);
        xfer(12'h190, 1'b1, 8'h90);
        pulse(w);
        chk("quiet idle", 0, w);
        per_low <= 1'b1;
        repeat (3) @(posedge pclk);
        per_low <= 1'b0;
        pulse(w);
        chk("quiet start", 4, w);
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
